// ### hw/rpfs_pkg.sv
// package: constants and carrier types for the reset and port b pin-function select block
package rpfs_pkg;

   // reset release count in internal clock cycles
   localparam int unsigned RELEASE_CYCLES = 32;

   // reset value of the reset-pin role select (0 = reset input)
   localparam logic RESET_PIN_ROLE_RST = 1'b0;

   // clock-output source encodings
   typedef enum logic [1:0] {
      RPFS_CLOCK_OUTPUT_PIN_OFF    = 2'h0,
      RPFS_CLOCK_OUTPUT_PIN_MASTER = 2'h1,
      RPFS_CLOCK_OUTPUT_PIN_BUS    = 2'h2,
      RPFS_CLOCK_OUTPUT_PIN_OSC    = 2'h3
   } rpfs_clock_output_pin_e;

   // role of the shared timer / clock-output line
   typedef enum logic [1:0] {
      RPFS_B4_GPIO  = 2'h0,
      RPFS_B4_TIMER = 2'h1,
      RPFS_B4_CLOCK_OUTPUT_PIN  = 2'h2
   } rpfs_b4_role_e;

   // role of the serial-clock capable line
   typedef enum logic {
      RPFS_B7_GPIO = 1'b0,
      RPFS_B7_SCL  = 1'b1
   } rpfs_b7_role_e;

   localparam logic [1:0] B4_ROLE_RST = 2'h0;
   localparam logic       B7_ROLE_RST = 1'b0;
   localparam logic [1:0] CLOCK_OUTPUT_PIN_SEL_RST = 2'h0;

   // pad triple: input level, output level, active-low output enable
   typedef struct packed {
      logic in;
      logic out;
      logic oe_n;
   } rpfs_pad_s;

   // software configuration
   typedef struct packed {
      logic          reset_pin_gpio;
      rpfs_b7_role_e b7_role;
      rpfs_b4_role_e b4_role;
      rpfs_clock_output_pin_e    clock_output_pin_sel;
   } rpfs_cfg_s;

   // per-line general purpose port controls
   typedef struct packed {
      logic out;
      logic dir_out;
   } rpfs_gpio_s;

endpackage

// ### hw/rpfs_sync.sv
// two-flop synchroniser for an asynchronous pin level
`timescale 1ns/1ps
module rpfs_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // clock and reset
   input  wire logic clock_i,
   input  wire logic reset_i,
   // level
   input  wire logic async_i,
   output logic      sync_o
);
   logic stage1;
   logic stage2;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2;
endmodule

// ### hw/rpfs_top.sv
// pin-function select for the reset pin and two shared port b lines
// Overview of operation
// - reset pin low in reset role holds whole chip in reset
// - internal reset ends synchronously after a fixed count of clocks
// - port a role: input or open-drain output, pin reset ignored
// - any reset returns the reset pin to its reset-input role
// - serial-clock line defaults to port b, peripheral role needs software
// - timer/clock-output line defaults to port b, roles set by software
// - clock-output source: off at 0, master clock, bus clock, oscillator
// - in serial-clock role the line is both input and output
// - each port b line individually programmable as input or output
`timescale 1ns/1ps
module rpfs_top #(
   parameter int unsigned RELEASE_CYCLES = rpfs_pkg::RELEASE_CYCLES
) (
   // clock and other reset sources
   input  wire logic                clock_i,
   input  wire logic                reset_i,
   input  wire logic                watchdog_reset_i,
   input  wire logic                soft_reset_i,
   // clock sources for the clock output
   input  wire logic                system_master_clock_i,
   input  wire logic                peripheral_bus_clock_i,
   input  wire logic                oscillator_clock_i,
   // software configuration
   input  wire rpfs_pkg::rpfs_cfg_s cfg_i,
   input  wire logic                cfg_write_i,
   // port a line on the reset pin
   input  wire logic                port_a_out_i,
   output logic                     port_a_in_o,
   // port b controls
   input  wire rpfs_pkg::rpfs_gpio_s port_b_line_seven_ctl_i,
   input  wire rpfs_pkg::rpfs_gpio_s port_b_line_four_ctl_i,
   output logic                     port_b_line_seven_in_o,
   output logic                     port_b_line_four_in_o,
   // serial clock from the i2c unit
   input  wire logic                scl_out_i,
   output logic                     scl_in_o,
   // timer channel zero
   input  wire logic                timer_channel_zero_out_i,
   input  wire logic                timer_channel_zero_oe_i,
   output logic                     timer_channel_zero_in_o,
   // reset pin pad
   input  wire logic                reset_pad_in_i,
   output logic                     reset_pad_out_o,
   output logic                     reset_pad_oe_n_o,
   // port b line seven pad
   input  wire logic                b7_pad_in_i,
   output logic                     b7_pad_out_o,
   output logic                     b7_pad_oe_n_o,
   // port b line four pad
   input  wire logic                b4_pad_in_i,
   output logic                     b4_pad_out_o,
   output logic                     b4_pad_oe_n_o,
   // chip reset
   output logic                     chip_reset_o
);
   localparam int CW = $clog2(RELEASE_CYCLES + 1);

   logic                reset_pin_sync;
   logic                b7_sync;
   logic                b4_sync;
   logic                any_reset;
   logic                pin_reset;
   rpfs_pkg::rpfs_cfg_s cfg;
   rpfs_pkg::rpfs_cfg_s next_cfg;
   logic [CW-1:0]       count;
   logic [CW-1:0]       next_count;
   logic                chip_reset;
   logic                next_chip_reset;
   logic                clock_output_pin_level;

   // pad levels are asynchronous to clock_i
   rpfs_sync #(.RESET_VAL(1'b1)) u_sync_rst (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .async_i (reset_pad_in_i),
      .sync_o  (reset_pin_sync)
   );
   rpfs_sync #(.RESET_VAL(1'b1)) u_sync_b7 (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .async_i (b7_pad_in_i),
      .sync_o  (b7_sync)
   );
   rpfs_sync #(.RESET_VAL(1'b1)) u_sync_b4 (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .async_i (b4_pad_in_i),
      .sync_o  (b4_sync)
   );

   // pin reset counts only while the pin is in its reset role
   assign pin_reset = !cfg.reset_pin_gpio && !reset_pin_sync;
   assign any_reset = pin_reset || watchdog_reset_i || soft_reset_i;

   // configuration: returns to defaults under any reset source
   always_comb begin
      next_cfg = cfg;
      if (chip_reset) begin
         next_cfg.reset_pin_gpio = rpfs_pkg::RESET_PIN_ROLE_RST;
         next_cfg.b7_role = rpfs_pkg::rpfs_b7_role_e'(rpfs_pkg::B7_ROLE_RST);
         next_cfg.b4_role = rpfs_pkg::rpfs_b4_role_e'(rpfs_pkg::B4_ROLE_RST);
         next_cfg.clock_output_pin_sel = rpfs_pkg::rpfs_clock_output_pin_e'(rpfs_pkg::CLOCK_OUTPUT_PIN_SEL_RST);
      end else if (cfg_write_i) begin
         next_cfg = cfg_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         cfg.reset_pin_gpio <= rpfs_pkg::RESET_PIN_ROLE_RST;
         cfg.b7_role        <= rpfs_pkg::RPFS_B7_GPIO;
         cfg.b4_role        <= rpfs_pkg::RPFS_B4_GPIO;
         cfg.clock_output_pin_sel       <= rpfs_pkg::RPFS_CLOCK_OUTPUT_PIN_OFF;
      end else begin
         cfg <= next_cfg;
      end
   end

   // release counter: reset held while a source is active, then a fixed count
   always_comb begin
      next_count      = count;
      next_chip_reset = chip_reset;
      if (any_reset) begin
         next_count      = '0;
         next_chip_reset = 1'b1;
      end else if (chip_reset) begin
         if (count == CW'(RELEASE_CYCLES - 1)) begin
            next_chip_reset = 1'b0;
         end else begin
            next_count = count + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         count      <= '0;
         chip_reset <= 1'b1;
      end else begin
         count      <= next_count;
         chip_reset <= next_chip_reset;
      end
   end

   assign chip_reset_o = chip_reset;

   // clock output is a plain mux; glitches on a source switch are accepted
   always_comb begin
      case (cfg.clock_output_pin_sel)
         rpfs_pkg::RPFS_CLOCK_OUTPUT_PIN_OFF:    clock_output_pin_level = 1'b0;
         rpfs_pkg::RPFS_CLOCK_OUTPUT_PIN_MASTER: clock_output_pin_level = system_master_clock_i;
         rpfs_pkg::RPFS_CLOCK_OUTPUT_PIN_BUS:    clock_output_pin_level = peripheral_bus_clock_i;
         rpfs_pkg::RPFS_CLOCK_OUTPUT_PIN_OSC:    clock_output_pin_level = oscillator_clock_i;
         default:                    clock_output_pin_level = 1'b0;
      endcase
   end

   // reset pin: open-drain port a, never driven high
   always_comb begin
      reset_pad_out_o  = 1'b0;
      reset_pad_oe_n_o = 1'b1;
      if (cfg.reset_pin_gpio && !port_a_out_i) begin
         reset_pad_oe_n_o = 1'b0;
      end
   end
   assign port_a_in_o = reset_pin_sync;

   // line seven: port b or open-drain serial clock
   always_comb begin
      b7_pad_out_o  = port_b_line_seven_ctl_i.out;
      b7_pad_oe_n_o = !port_b_line_seven_ctl_i.dir_out;
      case (cfg.b7_role)
         rpfs_pkg::RPFS_B7_SCL: begin
            b7_pad_out_o  = 1'b0;
            b7_pad_oe_n_o = scl_out_i;
         end
         default: begin
         end
      endcase
   end
   assign scl_in_o               = b7_sync;
   assign port_b_line_seven_in_o = b7_sync;

   // line four: port b, timer channel zero or clock output
   always_comb begin
      b4_pad_out_o  = port_b_line_four_ctl_i.out;
      b4_pad_oe_n_o = !port_b_line_four_ctl_i.dir_out;
      case (cfg.b4_role)
         rpfs_pkg::RPFS_B4_TIMER: begin
            b4_pad_out_o  = timer_channel_zero_out_i;
            b4_pad_oe_n_o = !timer_channel_zero_oe_i;
         end
         rpfs_pkg::RPFS_B4_CLOCK_OUTPUT_PIN: begin
            b4_pad_out_o  = clock_output_pin_level;
            b4_pad_oe_n_o = 1'b0;
         end
         default: begin
         end
      endcase
   end
   assign timer_channel_zero_in_o = b4_sync;
   assign port_b_line_four_in_o   = b4_sync;

   // assertions
   release_count_a: assert property (@(posedge clock_i) disable iff (reset_i)
      $fell(chip_reset) |-> $past(count) == CW'(RELEASE_CYCLES - 1))
      else $error("internal reset released before the fixed count");
   pin_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
      pin_reset |=> chip_reset)
      else $error("reset pin low did not hold chip reset");
   // a low pad in port a role must not start a chip reset; other sources excluded
   gpio_ignore_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cfg.reset_pin_gpio && !chip_reset && !watchdog_reset_i && !soft_reset_i
      |=> !chip_reset && !reset_pad_out_o)
      else $error("port a role still resets or drives high");
   role_default_a: assert property (@(posedge clock_i) disable iff (reset_i)
      chip_reset |=> !cfg.reset_pin_gpio)
      else $error("reset pin role not restored after reset");
   scl_default_a: assert property (@(posedge clock_i) disable iff (reset_i)
      chip_reset |=> cfg.b7_role == rpfs_pkg::RPFS_B7_GPIO)
      else $error("serial clock line not back to port b");
   b4_default_a: assert property (@(posedge clock_i) disable iff (reset_i)
      chip_reset |=> cfg.b4_role == rpfs_pkg::RPFS_B4_GPIO)
      else $error("timer line not back to port b");
   clock_output_pin_off_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cfg.b4_role == rpfs_pkg::RPFS_B4_CLOCK_OUTPUT_PIN && cfg.clock_output_pin_sel == rpfs_pkg::RPFS_CLOCK_OUTPUT_PIN_OFF
      |-> !b4_pad_out_o && !b4_pad_oe_n_o)
      else $error("disabled clock output not held low");
   scl_drive_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cfg.b7_role == rpfs_pkg::RPFS_B7_SCL |-> b7_pad_oe_n_o == scl_out_i && !b7_pad_out_o)
      else $error("serial clock line not open drain");
   gpio_dir_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cfg.b7_role == rpfs_pkg::RPFS_B7_GPIO
      |-> b7_pad_oe_n_o == !port_b_line_seven_ctl_i.dir_out)
      else $error("port b direction not followed");
   sync_path_a: assert property (@(posedge clock_i) disable iff (reset_i)
      (!cfg.reset_pin_gpio && !reset_pad_in_i) [*3] |-> pin_reset)
      else $error("synchronised reset pin level late");
endmodule

// ### bench/rpfs_board.sv
// board model: pad pull-ups, open-drain wiring and external pull-down drivers
`timescale 1ns/1ps
module rpfs_board (
   // device pad drives
   input  wire logic rst_out_i,
   input  wire logic rst_oe_n_i,
   input  wire logic b7_out_i,
   input  wire logic b7_oe_n_i,
   input  wire logic b4_out_i,
   input  wire logic b4_oe_n_i,
   // external drivers pulling each line low
   input  wire logic rst_low_i,
   input  wire logic b7_low_i,
   input  wire logic b4_low_i,
   // resolved pad levels
   output logic      rst_lvl_o,
   output logic      b7_lvl_o,
   output logic      b4_lvl_o
);
   // a released line floats up to the pull-up, never holds its last value
   assign rst_lvl_o = !rst_low_i && (rst_oe_n_i || rst_out_i);
   // device drive wins on a push-pull line; the serial clock is wired-and
   assign b7_lvl_o = !b7_oe_n_i ? (b7_out_i && !b7_low_i) : !b7_low_i;
   assign b4_lvl_o = !b4_oe_n_i ? b4_out_i : !b4_low_i;
endmodule

// ### bench/testbench.sv
// self-checking bench for the reset and port b pin-function select block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
   localparam int RC = 4;
   logic clock_i, reset_i, watchdog_reset_i, soft_reset_i, cfg_write_i, port_a_out_i;
   logic system_master_clock_i, peripheral_bus_clock_i, oscillator_clock_i;
   logic scl_out_i, timer_channel_zero_out_i, timer_channel_zero_oe_i, r_low, s7_low, s4_low;
   logic port_a_in_o, port_b_line_seven_in_o, port_b_line_four_in_o, scl_in_o;
   logic timer_channel_zero_in_o, chip_reset_o, r_lvl, s7_lvl, s4_lvl;
   logic reset_pad_out_o, reset_pad_oe_n_o, b7_pad_out_o, b7_pad_oe_n_o, b4_pad_out_o;
   logic b4_pad_oe_n_o;
   rpfs_pkg::rpfs_cfg_s  cfg_i;
   rpfs_pkg::rpfs_gpio_s c7, c4;
   int                   err_total, checks_done, cyc;

   rpfs_top #(.RELEASE_CYCLES(RC)) DUT (.clock_i, .reset_i, .watchdog_reset_i, .soft_reset_i,
      .system_master_clock_i, .peripheral_bus_clock_i, .oscillator_clock_i, .cfg_i,
      .cfg_write_i, .port_a_out_i, .port_a_in_o, .port_b_line_seven_ctl_i(c7),
      .port_b_line_four_ctl_i(c4), .port_b_line_seven_in_o, .port_b_line_four_in_o,
      .scl_out_i, .scl_in_o, .timer_channel_zero_out_i, .timer_channel_zero_oe_i,
      .timer_channel_zero_in_o, .reset_pad_in_i(r_lvl), .reset_pad_out_o, .reset_pad_oe_n_o,
      .b7_pad_in_i(s7_lvl), .b7_pad_out_o, .b7_pad_oe_n_o, .b4_pad_in_i(s4_lvl),
      .b4_pad_out_o, .b4_pad_oe_n_o, .chip_reset_o);

   rpfs_board board (.rst_out_i(reset_pad_out_o), .rst_oe_n_i(reset_pad_oe_n_o),
      .b7_out_i(b7_pad_out_o), .b7_oe_n_i(b7_pad_oe_n_o), .b4_out_i(b4_pad_out_o),
      .b4_oe_n_i(b4_pad_oe_n_o), .rst_low_i(r_low), .b7_low_i(s7_low), .b4_low_i(s4_low),
      .rst_lvl_o(r_lvl), .b7_lvl_o(s7_lvl), .b4_lvl_o(s4_lvl));

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   task automatic give_verdict();
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic tick(int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   // roles as raw codes: b7 1 = serial clock, b4 1 = timer, 2 = clock output
   task automatic wcfg(logic g, logic r7, logic [1:0] r4, logic [1:0] s);
      @(posedge clock_i);
      cfg_i <= '{g, rpfs_pkg::rpfs_b7_role_e'(r7), rpfs_pkg::rpfs_b4_role_e'(r4),
                 rpfs_pkg::rpfs_clock_output_pin_e'(s)};
      cfg_write_i <= 1'b1;
      @(posedge clock_i);
      cfg_write_i <= 1'b0;
      #1;
   endtask

   task automatic wait_run(output int n);
      n = 0;
      while (chip_reset_o !== 1'b0 && n < 100) begin
         tick(1);
         n++;
      end
   endtask

   task automatic t_reset();
      int n;
      @(posedge clock_i);
      reset_i <= 1'b0;
      wait_run(n);
      `CHK("release_min", 1'b1, n >= RC)
      `CHK("release_max", 1'b1, n <= RC + 6)
      `CHK("rst_oe_n", 1'b1, reset_pad_oe_n_o)
      `CHK("b7_oe_n", 1'b1, b7_pad_oe_n_o)
      `CHK("b4_oe_n", 1'b1, b4_pad_oe_n_o)
   endtask

   task automatic t_pin_reset();
      int n;
      wcfg(1'b0, 1'b0, 2'h2, 2'h0);
      `CHK("b4_oe_n_clock_output_pin", 1'b0, b4_pad_oe_n_o)
      @(posedge clock_i);
      r_low <= 1'b1;
      tick(1);
      `CHK("chip_rst_sync", 1'b0, chip_reset_o)
      tick(4);
      `CHK("chip_rst_pin", 1'b1, chip_reset_o)
      `CHK("b4_oe_n_dflt", 1'b1, b4_pad_oe_n_o)
      tick(RC + 6);
      `CHK("chip_rst_hold", 1'b1, chip_reset_o)
      @(posedge clock_i);
      r_low <= 1'b0;
      wait_run(n);
      `CHK("pin_release", 1'b1, n >= RC)
   endtask

   task automatic t_port_a();
      int n;
      wcfg(1'b1, 1'b0, 2'h0, 2'h0);
      @(posedge clock_i);
      port_a_out_i <= 1'b0;
      tick(1);
      `CHK("pa_oe_n_low", 1'b0, reset_pad_oe_n_o)
      `CHK("pa_out_low", 1'b0, reset_pad_out_o)
      @(posedge clock_i);
      port_a_out_i <= 1'b1;
      tick(1);
      `CHK("pa_oe_n_high", 1'b1, reset_pad_oe_n_o)
      @(posedge clock_i);
      r_low <= 1'b1;
      tick(8);
      `CHK("pa_no_reset", 1'b0, chip_reset_o)
      `CHK("pa_in", 1'b0, port_a_in_o)
      @(posedge clock_i);
      r_low <= 1'b0;
      watchdog_reset_i <= 1'b1;
      tick(2);
      `CHK("wdog_rst", 1'b1, chip_reset_o)
      @(posedge clock_i);
      watchdog_reset_i <= 1'b0;
      port_a_out_i <= 1'b0;
      wait_run(n);
      `CHK("rst_role_back", 1'b1, reset_pad_oe_n_o)
      @(posedge clock_i);
      port_a_out_i <= 1'b1;
   endtask

   task automatic t_clock_output_pin();
      logic e;
      for (int k = 0; k < 4; k++) begin
         wcfg(1'b0, 1'b0, 2'h2, k[1:0]);
         for (int v = 0; v < 2; v++) begin
            @(posedge clock_i);
            system_master_clock_i <= (k == 1) ? v[0] : !v[0];
            peripheral_bus_clock_i <= (k == 2) ? v[0] : !v[0];
            oscillator_clock_i <= (k == 3) ? v[0] : !v[0];
            #1;
            e = (k == 0) ? 1'b0 : v[0];
            `CHK("clock_output_pin_out", e, b4_pad_out_o)
            `CHK("clock_output_pin_oe_n", 1'b0, b4_pad_oe_n_o)
         end
      end
   endtask

   task automatic t_scl();
      int n;
      wcfg(1'b0, 1'b1, 2'h0, 2'h0);
      @(posedge clock_i);
      scl_out_i <= 1'b0;
      tick(1);
      `CHK("scl_oe_n_low", 1'b0, b7_pad_oe_n_o)
      `CHK("scl_out_low", 1'b0, b7_pad_out_o)
      @(posedge clock_i);
      scl_out_i <= 1'b1;
      tick(3);
      `CHK("scl_released", 1'b1, b7_pad_oe_n_o)
      `CHK("scl_in_high", 1'b1, scl_in_o)
      @(posedge clock_i);
      s7_low <= 1'b1;
      tick(3);
      `CHK("scl_in_low", 1'b0, scl_in_o)
      `CHK("b7_in_low", 1'b0, port_b_line_seven_in_o)
      @(posedge clock_i);
      s7_low <= 1'b0;
      soft_reset_i <= 1'b1;
      tick(2);
      `CHK("soft_rst", 1'b1, chip_reset_o)
      @(posedge clock_i);
      soft_reset_i <= 1'b0;
      scl_out_i <= 1'b0;
      wait_run(n);
      `CHK("b7_gpio_back", 1'b1, b7_pad_oe_n_o)
      @(posedge clock_i);
      scl_out_i <= 1'b1;
   endtask

   task automatic t_gpio();
      wcfg(1'b0, 1'b0, 2'h1, 2'h0);
      @(posedge clock_i);
      timer_channel_zero_out_i <= 1'b1;
      timer_channel_zero_oe_i <= 1'b1;
      tick(1);
      `CHK("tmr_oe_n", 1'b0, b4_pad_oe_n_o)
      `CHK("tmr_out", 1'b1, b4_pad_out_o)
      @(posedge clock_i);
      timer_channel_zero_oe_i <= 1'b0;
      s4_low <= 1'b1;
      tick(3);
      `CHK("tmr_in", 1'b0, timer_channel_zero_in_o)
      wcfg(1'b0, 1'b0, 2'h0, 2'h0);
      @(posedge clock_i);
      c7 <= '{1'b1, 1'b1};
      c4 <= '{1'b0, 1'b0};
      tick(3);
      `CHK("b7_drive", 1'b0, b7_pad_oe_n_o)
      `CHK("b7_value", 1'b1, b7_pad_out_o)
      `CHK("b4_input", 1'b1, b4_pad_oe_n_o)
      `CHK("b4_in_low", 1'b0, port_b_line_four_in_o)
      `CHK("b7_in_high", 1'b1, port_b_line_seven_in_o)
      @(posedge clock_i);
      c7 <= '{1'b0, 1'b0};
      c4 <= '{1'b1, 1'b1};
      s4_low <= 1'b0;
      tick(3);
      `CHK("b7_input", 1'b1, b7_pad_oe_n_o)
      `CHK("b4_drive", 1'b0, b4_pad_oe_n_o)
      `CHK("b4_in_high", 1'b1, port_b_line_four_in_o)
   endtask

   initial begin
      {watchdog_reset_i, soft_reset_i, cfg_write_i, r_low, s7_low, s4_low} = '0;
      {system_master_clock_i, peripheral_bus_clock_i, oscillator_clock_i} = '0;
      // peripheral drives active from the start, so a wrong default role shows on the pads
      {timer_channel_zero_out_i, timer_channel_zero_oe_i} = 2'h1;
      {port_a_out_i, scl_out_i, reset_i} = 3'h1;
      cfg_i = '0;
      c7 = '0;
      c4 = '0;
      tick(11);
      t_reset();
      t_pin_reset();
      t_port_a();
      t_clock_output_pin();
      t_scl();
      t_gpio();
      give_verdict();
   end
endmodule
